// ### src/loop_mux.sv
// loopback routing of serial and infrared lines
`timescale 1ns/1ns
module loop_mux (
  input  wire logic loop_en,     // loopback active
  input  wire logic ir_en,       // infrared mode
  input  wire logic tx_data,     // internal serial tx data
  input  wire logic ext_rx,      // serial in pin
  input  wire logic ext_ir_rx,   // ir in pin
  output logic      tx_pin_d,    // next serial out
  output logic      ir_pin_d,    // next ir out
  output logic      rx_int,      // internal serial rx
  output logic      ir_rx_int    // internal ir rx
);
  always_comb begin
    tx_pin_d  = tx_data;
    ir_pin_d  = ~tx_data;
    rx_int    = ext_rx;
    ir_rx_int = ext_ir_rx;
    if (loop_en && !ir_en) begin
      tx_pin_d = 1'b1;
      rx_int   = tx_data;
    end
    if (loop_en && ir_en) begin
      ir_pin_d  = 1'b0;
      ir_rx_int = ~tx_data;
    end
  end
endmodule // loop_mux

// ### src/modem_ctrl_pkg.sv
// package of constants for the modem-control block
// Functional notes
// - auto flow enable bit writable only when feature configured; always readable.
// - auto flow active only while fifos enabled and enable bit is one.
// - uart loopback holds serial out high, routes tx data to rx input.
// - interrupt sources keep working normally during uart loopback.
// - uart loopback disconnects modem status inputs, feeds control outputs back.
// - infrared loopback holds ir out low, routes inverted tx data to ir input.
// - each user output pin is the inverse of its control bit.
// - loopback holds user outputs high and loops their bits back inward.
// - without auto flow, rts pin low when its bit is one.
// - with auto flow active, rts forced high while rx fifo above threshold.
// - loopback holds rts pin high and loops rts bit back inward.
// - infrared enable bit selects uart or infrared serial behaviour.
package modem_ctrl_pkg;
  localparam logic [31:0] modem_line_control_addr = 32'h5000_1110;
  localparam int          rts_pos                 = 1;
  localparam int          user_one_pos            = 2;
  localparam int          user_two_pos            = 3;
  localparam int          loopback_pos            = 4;
  localparam int          afce_pos                = 5;
  localparam int          ir_pos                  = 6;
  localparam logic [15:0] modem_ctrl_reset        = 16'h0000;
  localparam logic [15:0] modem_ctrl_rw_mask      = 16'h007E;
endpackage

// ### src/uart_modem_control.sv
// modem control register and modem line steering
`timescale 1ns/1ns
module uart_modem_control
  import modem_ctrl_pkg::*;
#(
  parameter bit auto_flow_feature_config = 1'b1  // auto flow built in
) (
  input  wire logic        clk,              // 250 mhz clock
  input  wire logic        rst,              // async reset, high
  input  wire logic [31:0] addr,             // register address
  input  wire logic [15:0] wdata,            // write data
  input  wire logic        wr,               // write strobe
  input  wire logic        rd,               // read strobe
  output logic      [15:0] rdata,            // read data, cycle after rd
  input  wire logic        fifo_enable,      // fifo control reg bit 0
  input  wire logic        rx_above_thresh,  // rx fifo above threshold
  input  wire logic        dtr_bit,          // dtr control bit from elsewhere
  input  wire logic        tx_data,          // internal serial tx
  input  wire logic        sin,              // serial in pin
  input  wire logic        sir_in,           // ir in pin
  input  wire logic        cts_n,            // modem status input
  input  wire logic        dsr_n,            // modem status input
  input  wire logic        ring_indicator_n, // modem status input
  input  wire logic        dcd_n,            // modem status input
  output logic             sout,             // serial out pin
  output logic             sir_out_n,        // ir out pin
  output logic             rx_int,           // serial rx to receiver
  output logic             ir_rx_int,        // ir rx to receiver
  output logic             cts_int_n,        // status seen by core
  output logic             dsr_int_n,        // status seen by core
  output logic             ri_int_n,         // status seen by core
  output logic             dcd_int_n,        // status seen by core
  output logic             rts_n,            // request to send pin
  output logic             user_output_one_n, // user output 1
  output logic             user_output_two_n, // user output 2
  output logic             infrared_mode,    // ir select for serial core
  output logic             auto_flow_active  // auto flow in force
);
  // ****************************************
  // register
  // ****************************************
  logic [15:0] modem_control_reg_q, modem_control_reg_d;
  logic [15:0] rdata_d;
  logic        sel;
  logic        tx_pin_d, ir_pin_d;
  logic        rts_n_d, u1_n_d, u2_n_d;
  logic        sout_q, sir_q;
  logic        loopback_bit, auto_flow_ctrl_enable_bit, infrared_enable_bit;
  logic        user_output_one_bit, user_output_two_bit, rts_bit;

  assign sel = (addr == modem_line_control_addr);

  function automatic logic [15:0] write_mask(input bit afc_cfg);
    logic [15:0] m;
    m = modem_ctrl_rw_mask;
    if (!afc_cfg) m[afce_pos] = 1'b0;
    return m;
  endfunction

  always_comb begin
    modem_control_reg_d = modem_control_reg_q;
    if (wr && sel) begin
      modem_control_reg_d = (wdata & write_mask(auto_flow_feature_config)) |
                            (modem_control_reg_q & ~write_mask(auto_flow_feature_config));
    end
    rdata_d = 16'h0000;
    if (rd && sel) rdata_d = modem_control_reg_q;
  end

  assign loopback_bit              = modem_control_reg_q[loopback_pos];
  assign auto_flow_ctrl_enable_bit = modem_control_reg_q[afce_pos];
  assign infrared_enable_bit       = modem_control_reg_q[ir_pos];
  assign user_output_one_bit       = modem_control_reg_q[user_one_pos];
  assign user_output_two_bit       = modem_control_reg_q[user_two_pos];
  assign rts_bit                   = modem_control_reg_q[rts_pos];
  assign infrared_mode             = infrared_enable_bit;
  assign auto_flow_active          = fifo_enable & auto_flow_ctrl_enable_bit;

  // ****************************************
  // modem outputs
  // ****************************************
  always_comb begin
    u1_n_d  = ~user_output_one_bit;
    u2_n_d  = ~user_output_two_bit;
    rts_n_d = ~rts_bit;
    if (auto_flow_active && rx_above_thresh) rts_n_d = 1'b1;
    if (loopback_bit) begin
      u1_n_d  = 1'b1;
      u2_n_d  = 1'b1;
      rts_n_d = 1'b1;
    end
  end

  // status inputs swap to the looped control bits; interrupt logic downstream
  // sees these nets unchanged in form, so it keeps working in loopback
  always_comb begin
    cts_int_n = cts_n;
    dsr_int_n = dsr_n;
    ri_int_n  = ring_indicator_n;
    dcd_int_n = dcd_n;
    if (loopback_bit) begin
      cts_int_n = ~rts_bit;
      dsr_int_n = ~dtr_bit;
      ri_int_n  = ~user_output_one_bit;
      dcd_int_n = ~user_output_two_bit;
    end
  end

  loop_mux u_loop (
    .loop_en   (loopback_bit),
    .ir_en     (infrared_enable_bit),
    .tx_data   (tx_data),
    .ext_rx    (sin),
    .ext_ir_rx (sir_in),
    .tx_pin_d  (tx_pin_d),
    .ir_pin_d  (ir_pin_d),
    .rx_int    (rx_int),
    .ir_rx_int (ir_rx_int)
  );

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modem_control_reg_q <= modem_ctrl_reset;
      rdata               <= 16'h0000;
      rts_n               <= 1'b1;
      user_output_one_n   <= 1'b1;
      user_output_two_n   <= 1'b1;
      sout_q              <= 1'b1;
      sir_q               <= 1'b1;
    end else begin
      modem_control_reg_q <= modem_control_reg_d;
      rdata               <= rdata_d;
      rts_n               <= rts_n_d;
      user_output_one_n   <= u1_n_d;
      user_output_two_n   <= u2_n_d;
      sout_q              <= tx_pin_d;
      sir_q               <= ir_pin_d;
    end
  end

  assign sout      = sout_q;
  assign sir_out_n = sir_q;
endmodule // uart_modem_control

// ### verification/modem_ctrl_properties.sv
// concurrent checks on the modem control ports
`timescale 1ns/1ns
module modem_ctrl_properties
  import modem_ctrl_pkg::*;
#(
  parameter bit auto_flow_feature_config = 1'b1  // auto flow built in
) (
  input wire logic        clk,               // system clock
  input wire logic        rst,               // async reset, high
  input wire logic        wr,                // write strobe
  input wire logic [31:0] addr,              // register address
  input wire logic [15:0] wdata,             // write data
  input wire logic        fifo_enable,       // fifos on
  input wire logic        rx_above_thresh,   // rx fifo above threshold
  input wire logic        dtr_bit,           // dtr control bit
  input wire logic        tx_data,           // internal serial tx
  input wire logic        rx_int,            // internal serial rx
  input wire logic        ir_rx_int,         // internal ir rx
  input wire logic        sout,              // serial out pin
  input wire logic        sir_out_n,         // ir out pin
  input wire logic        rts_n,             // request to send pin
  input wire logic        cts_int_n,         // status seen by core
  input wire logic        dsr_int_n,         // status seen by core
  input wire logic        ri_int_n,          // status seen by core
  input wire logic        dcd_int_n,         // status seen by core
  input wire logic        user_output_one_n, // user output 1
  input wire logic        user_output_two_n, // user output 2
  input wire logic        infrared_mode,     // ir select
  input wire logic        auto_flow_active   // auto flow in force
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic hit;
  assign hit = wr && addr == modem_line_control_addr;
  sequence lb_s; hit && wdata[4]; endsequence
  loop_pins_a: assert property (lb_s |-> ##2 rts_n && user_output_one_n)
    else $error("loopback pins");
  loop_two_a: assert property (lb_s |-> ##2 user_output_two_n)
    else $error("loopback user two");
  uart_loop_a: assert property (lb_s ##0 !wdata[6] |-> ##1 rx_int == tx_data ##1 sout)
    else $error("uart loopback");
  ir_loop_a: assert property (lb_s ##0 wdata[6] |-> ##1 ir_rx_int != tx_data ##1 !sir_out_n)
    else $error("ir loopback");
  user_out_a: assert property (hit && !wdata[4] |-> ##2 user_output_one_n == !$past(wdata[2], 2))
    else $error("user output");
  rts_plain_a: assert property (hit && wdata[5:4] == 2'b00 |-> ##2 rts_n == !$past(wdata[1], 2))
    else $error("rts level");
  status_loop_a: assert property (lb_s |=> cts_int_n == !$past(wdata[1])
    && ri_int_n == !$past(wdata[2]) && dcd_int_n == !$past(wdata[3]) && dsr_int_n == !dtr_bit)
    else $error("status loop");
  mode_flags_a: assert property (hit |=> infrared_mode == $past(wdata[6])
    && auto_flow_active == ($past(wdata[5]) && auto_flow_feature_config && fifo_enable))
    else $error("mode flags");
  rts_gate_a: assert property (auto_flow_active && rx_above_thresh |=> rts_n)
    else $error("rts gate");
endmodule // modem_ctrl_properties
bind uart_modem_control modem_ctrl_properties #(
  .auto_flow_feature_config (auto_flow_feature_config)
) i_props (.clk, .rst, .wr, .addr, .wdata, .fifo_enable, .rx_above_thresh, .dtr_bit,
  .tx_data, .rx_int, .ir_rx_int, .sout, .sir_out_n, .rts_n, .cts_int_n, .dsr_int_n,
  .ri_int_n, .dcd_int_n, .user_output_one_n, .user_output_two_n, .infrared_mode,
  .auto_flow_active);

// ### verification/modem_peer.sv
// modem model on the far side of the modem control lines
`timescale 1ns/1ns
module modem_peer (
  input  wire logic clk,                     // system clock
  input  wire logic rts_n,                   // request from the uart
  input  wire logic ring,                    // bench rings the line
  output logic      cts_n = 1'b1,            // clear to send, one cycle late
  output logic      dsr_n,                   // data set ready
  output logic      ring_indicator_n,        // ring indicator
  output logic      dcd_n                    // carrier detect
);
  // a slow data set: grant follows the request a cycle later
  always @(posedge clk) cts_n <= rts_n;
  assign dsr_n = 1'b0;
  assign ring_indicator_n = !ring;
  assign dcd_n = 1'b0;
endmodule // modem_peer

// ### verification/testbench.sv
// self-checking bench for the modem control block
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module testbench;
  import modem_ctrl_pkg::*;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, fifo_enable = 0, rx_above_thresh = 0;
  logic        dtr_bit = 1, tx_data = 0, sin = 1, sir_in = 0, ring = 0;
  logic [31:0] addr = 32'h0000_0000;
  logic [15:0] wdata = 16'h0000, rdata;
  logic        sout, sir_out_n, rx_int, ir_rx_int, cts_n, dsr_n, ring_indicator_n, dcd_n;
  logic        cts_int_n, dsr_int_n, ri_int_n, dcd_int_n, rts_n, infrared_mode;
  logic        auto_flow_active, user_output_one_n, user_output_two_n;
  int          n_fail = 0, checks = 0;
  always #2 clk = ~clk;
  always @(posedge clk) tx_data <= ~tx_data;
  uart_modem_control i_uart_modem_control (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .fifo_enable, .rx_above_thresh, .dtr_bit, .tx_data, .sin, .sir_in, .cts_n, .dsr_n,
    .ring_indicator_n, .dcd_n, .sout, .sir_out_n, .rx_int, .ir_rx_int, .cts_int_n,
    .dsr_int_n, .ri_int_n, .dcd_int_n, .rts_n, .user_output_one_n, .user_output_two_n,
    .infrared_mode, .auto_flow_active);
  modem_peer i_modem_peer (.clk, .rts_n, .ring, .cts_n, .dsr_n, .ring_indicator_n, .dcd_n);
  // waits long enough for the peer's late answer to land too
  task automatic put(input logic [31:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic get(input logic [31:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
    @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    `CHK({rts_n, user_output_one_n, user_output_two_n, sout}, 4'hF)
    `CHK({infrared_mode, auto_flow_active, sir_out_n}, 3'h1)
    get(modem_line_control_addr, 16'h0000);
    put(modem_line_control_addr, 16'hFFFF);
    get(modem_line_control_addr, 16'h007E);
    `CHK({sir_out_n, ir_rx_int ^ tx_data, rts_n, infrared_mode}, 4'h7)
    put(32'h5000_1114, 16'h0000);
    get(32'h5000_1114, 16'h0000);
    get(modem_line_control_addr, 16'h007E);
    $display("register test done");
    // dtr low and out2 clear, so every looped status differs from the peer's level
    dtr_bit <= 1'b0;
    put(modem_line_control_addr, 16'h0016);
    `CHK({sout, rx_int ^ tx_data, cts_int_n, dsr_int_n, ri_int_n, dcd_int_n}, 6'h25)
    `CHK({rts_n, user_output_one_n, user_output_two_n}, 3'h7)
    ring <= 1'b1;
    put(modem_line_control_addr, 16'h000E);
    `CHK({rts_n, user_output_one_n, user_output_two_n, cts_int_n, ri_int_n}, 5'h00)
    `CHK({dsr_int_n, dcd_int_n, rx_int, ir_rx_int}, 4'h2)
    `CHK({sout ^ tx_data, sir_out_n ^ tx_data}, 2'h2)
    $display("loopback test done");
    fifo_enable <= 1'b1;
    rx_above_thresh <= 1'b1;
    put(modem_line_control_addr, 16'h0022);
    `CHK({auto_flow_active, rts_n}, 2'h3)
    rx_above_thresh <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(rts_n, 1'b0)
    fifo_enable <= 1'b0;
    rx_above_thresh <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({auto_flow_active, rts_n}, 2'h0)
    $display("flow test done");
    report_and_stop;
  end
endmodule // testbench
